// ===== hw/wbc_pkg.sv
// shared constants and types for the cpu write block cache sequencer
package wbc_pkg;

    // clock and address set-up times
    localparam int unsigned CLK_PERIOD_NS   = 10;
    localparam int unsigned PROBE_SETUP_NS  = 10;
    localparam int unsigned SHORT_SETUP_NS  = 4;
    // least times round up, never below one cycle
    localparam int unsigned PROBE_SETUP_RAW =
        (PROBE_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned SHORT_SETUP_RAW =
        (SHORT_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned PROBE_SETUP_CYC =
        (PROBE_SETUP_RAW < 1) ? 1 : PROBE_SETUP_RAW;
    localparam int unsigned SHORT_SETUP_CYC =
        (SHORT_SETUP_RAW < 1) ? 1 : SHORT_SETUP_RAW;
    localparam int unsigned SETUP_CNT_W     = 4;

    // bus geometry
    localparam int unsigned OCT_W           = 128;
    localparam int unsigned LINE_W          = 2 * OCT_W;
    localparam int unsigned LINE_BYTES      = LINE_W / 8;
    localparam int unsigned ADDR_W          = 34;
    localparam int unsigned LINE_LSB        = 5;
    localparam int unsigned TAG_LSB         = 17;
    localparam int unsigned TAG_W           = ADDR_W - TAG_LSB;
    localparam int unsigned IO_SPACE_BIT    = 33;

    typedef logic [2:0] wbc_code_t;
    localparam wbc_code_t REQ_IDLE          = 3'h0;
    localparam wbc_code_t REQ_WRITE_BLOCK   = 3'h7;
    localparam wbc_code_t ACK_IDLE          = 3'h0;
    localparam wbc_code_t ACK_OK            = 3'h1;

    typedef struct packed {
        logic             valid;
        logic             dirty;
        logic [TAG_W-1:0] tag;
    } wbc_tag_t;

    localparam wbc_tag_t TAG_RESET          = '0;

endpackage : wbc_pkg

// ===== hw/wbc_bus_if.sv
// system bus between the processor end and the cache controller end
`timescale 1ns/1ps
`default_nettype none
interface wbc_bus_if;
    import wbc_pkg::*;

    wbc_code_t                proc_cycle_request;
    wbc_code_t                proc_cycle_acknowledge;
    logic [ADDR_W-1:0]        system_address_bus;
    logic [LINE_BYTES-1:0]    proc_write_mask;
    logic                     proc_data_output_enable_n;
    logic                     proc_data_word_select;
    logic                     proc_dcache_invalidate_request;
    logic [OCT_W-1:0]         proc_data_bus;
    logic                     proc_data_oe;
    logic [OCT_W-1:0]         ctrl_data_out;
    logic                     ctrl_data_oe;
    logic [OCT_W-1:0]         system_data_bus;

    // processor drivers open only while its output enable pin is low
    logic proc_drive;
    assign proc_drive      = proc_data_oe & ~proc_data_output_enable_n;
    assign system_data_bus = proc_drive   ? proc_data_bus :
                             ctrl_data_oe ? ctrl_data_out : '0;

    modport ctrl (
        input  proc_cycle_request,
        input  system_address_bus,
        input  proc_write_mask,
        input  system_data_bus,
        output proc_cycle_acknowledge,
        output proc_data_output_enable_n,
        output proc_data_word_select,
        output proc_dcache_invalidate_request,
        output ctrl_data_out,
        output ctrl_data_oe
    );

    modport proc (
        output proc_cycle_request,
        output system_address_bus,
        output proc_write_mask,
        output proc_data_bus,
        output proc_data_oe,
        input  proc_cycle_acknowledge,
        input  proc_data_output_enable_n,
        input  proc_data_word_select,
        input  proc_dcache_invalidate_request,
        input  system_data_bus
    );

endinterface : wbc_bus_if
`default_nettype wire

// ===== hw/wbc_byte_merge.sv
// byte-wise merge of written bytes into a line fetched from memory
`timescale 1ns/1ps
`default_nettype none
module wbc_byte_merge #(
    parameter int unsigned BYTES = 32
) (
    input  wire logic [BYTES*8-1:0] write_line_in,
    input  wire logic [BYTES-1:0]   write_mask_in,
    input  wire logic [BYTES*8-1:0] memory_line_in,
    output logic      [BYTES*8-1:0] merged_line_out
);

    for (genvar i = 0; i < BYTES; i++) begin : g_byte
        assign merged_line_out[i*8 +: 8] = write_mask_in[i] ?
            write_line_in[i*8 +: 8] : memory_line_in[i*8 +: 8];
    end

endmodule : wbc_byte_merge
`default_nettype wire

// ===== hw/wbc_ctrl_end.sv
// cache controller end: write block sequencer for cacheable space
`timescale 1ns/1ps
`default_nettype none
module wbc_ctrl_end
    import wbc_pkg::*;
(
    input  wire logic                  sys_clk_in,
    input  wire logic                  resetn_in,
    wbc_bus_if.ctrl                    bus,
    input  wire logic                  write_allocate_enable_in,
    input  wire wbc_tag_t              cache_tag_in,
    output logic                       early_output_enable_gate_out,
    output logic                       cache_tag_output_enable_out,
    output logic                       tag_output_gate_out,
    output logic                       system_data_enable_out,
    output logic                       cache_tag_drive_out,
    output wbc_tag_t                   cache_tag_out,
    output logic                       tag_write_enable_gate_out,
    output logic                       data_write_enable_gate_out,
    output logic                       cache_tag_write_strobe_out,
    output logic                       cache_data_write_strobe_out,
    output logic                       cache_data_addr_bit4_out,
    output logic                       mem_read_req_out,
    output logic [ADDR_W-1:0]          mem_read_addr_out,
    input  wire logic                  mem_read_valid_in,
    input  wire logic [LINE_W-1:0]     mem_read_data_in,
    output logic                       line_write_valid_out,
    output logic [ADDR_W-1:0]          line_write_addr_out,
    output logic [LINE_W-1:0]          line_write_data_out,
    output logic [LINE_BYTES-1:0]      line_write_mask_out
);

    typedef enum logic [3:0] {
        S_IDLE,
        S_C2,
        S_C3_ALLOC,
        S_C4,
        S_FETCH,
        S_C5,
        S_C6,
        S_C7,
        S_C3_NOALLOC
    } wbc_ctl_state_t;

    wbc_ctl_state_t          state_q;
    wbc_ctl_state_t          state_d;

    logic [ADDR_W-1:0]       addr_q;
    logic [LINE_BYTES-1:0]   mask_q;
    logic                    cacheable_q;
    logic [OCT_W-1:0]        oct0_q;
    logic [OCT_W-1:0]        oct1_q;
    logic                    old_valid_q;
    logic [LINE_W-1:0]       fill_line_q;

    logic                    early_gate_q;
    logic                    tag_oe_q;
    logic                    tag_gate_q;
    logic                    sys_den_q;
    logic                    word_sel_q;
    logic                    data_oe_n_q;
    logic                    tag_drive_q;
    wbc_tag_t                tag_out_q;
    logic                    tag_we_q;
    logic                    data_we_q;
    logic                    bit4_q;
    logic                    inval_q;
    wbc_code_t               ack_q;
    logic                    ctrl_oe_q;
    logic [OCT_W-1:0]        ctrl_data_q;
    logic                    mem_req_q;
    logic                    lw_valid_q;
    logic [LINE_W-1:0]       lw_data_q;

    ////////////////////////////////////////////////////////////////////////
    // decode

    wire wb_req     = early_gate_q &&
                      (bus.proc_cycle_request == REQ_WRITE_BLOCK);
    wire addr_cache = ~bus.system_address_bus[IO_SPACE_BIT];
    // only a dirty line of another address would need a write-back
    wire victim     = cache_tag_in.valid && cache_tag_in.dirty &&
                      (cache_tag_in.tag != addr_q[ADDR_W-1:TAG_LSB]);
    wire allocate   = write_allocate_enable_in && cacheable_q;
    wire full_line  = &mask_q;
    wire [LINE_W-1:0] write_line = {oct1_q, oct0_q};
    wire [LINE_W-1:0] merged_line;
    wire [LINE_W-1:0] fill_src = (state_q == S_FETCH) ?
                                 merged_line : write_line;

    wbc_byte_merge #(
        .BYTES           (LINE_BYTES)
    ) u_merge (
        .write_line_in   (write_line),
        .write_mask_in   (mask_q),
        .memory_line_in  (mem_read_data_in),
        .merged_line_out (merged_line)
    );

    ////////////////////////////////////////////////////////////////////////
    // sequence

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            S_IDLE: begin
                if (wb_req) begin
                    state_d = S_C2;
                end
            end
            S_C2: begin
                // a dirty victim is not filled here; the line goes out
                // through the data path instead
                if (allocate && !victim) begin
                    state_d = S_C3_ALLOC;
                end else begin
                    state_d = S_C3_NOALLOC;
                end
            end
            S_C3_ALLOC:   state_d = S_C4;
            S_C4:         state_d = full_line ? S_C5 : S_FETCH;
            S_FETCH:      if (mem_read_valid_in) state_d = S_C5;
            S_C5:         state_d = S_C6;
            S_C6:         state_d = S_C7;
            S_C7:         state_d = S_IDLE;
            S_C3_NOALLOC: state_d = S_IDLE;
        endcase
    end

    // output values follow the state being entered, so each registered output
    // but lw_valid_q and lw_data_q lines up with the cycle of that state
    wire in_c2     = (state_d == S_C2);
    wire in_c3     = (state_d == S_C3_ALLOC) || (state_d == S_C3_NOALLOC);
    wire early_d   = (state_d == S_IDLE) || in_c2;
    wire data_oe_d = in_c2 || in_c3 || (state_d == S_C7);
    wire tag_drv_d = (state_d == S_C4) || (state_d == S_FETCH) ||
                     (state_d == S_C5);
    wire dwe_d     = (state_d == S_C5) || (state_d == S_C6);
    wire twe_d     = (state_d == S_C5);
    wire inval_d   = (state_d == S_C5) && old_valid_q;
    wire ack_d     = (state_d == S_C7) ||
                     (state_d == S_C3_NOALLOC);
    wire ctrl_oe_d = dwe_d;
    wire [OCT_W-1:0] ctrl_data_d = (state_d == S_C5) ?
                     fill_src[OCT_W-1:0] : fill_line_q[LINE_W-1:OCT_W];

    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            state_q     <= S_IDLE;
            early_gate_q <= 1'b1;
            tag_oe_q    <= 1'b0;
            tag_gate_q  <= 1'b0;
            sys_den_q   <= 1'b0;
            word_sel_q  <= 1'b0;
            data_oe_n_q <= 1'b1;
            tag_drive_q <= 1'b0;
            tag_we_q    <= 1'b0;
            data_we_q   <= 1'b0;
            bit4_q      <= 1'b0;
            inval_q     <= 1'b0;
            ack_q       <= ACK_IDLE;
            ctrl_oe_q   <= 1'b0;
            mem_req_q   <= 1'b0;
            lw_valid_q  <= 1'b0;
        end else begin
            state_q     <= state_d;
            early_gate_q <= early_d;
            tag_oe_q    <= in_c2;
            tag_gate_q  <= in_c2;
            sys_den_q   <= in_c2;
            word_sel_q  <= in_c2;
            data_oe_n_q <= ~data_oe_d;
            tag_drive_q <= tag_drv_d;
            tag_we_q    <= twe_d;
            data_we_q   <= dwe_d;
            bit4_q      <= dwe_d;
            inval_q     <= inval_d;
            ack_q       <= ack_d ? ACK_OK : ACK_IDLE;
            ctrl_oe_q   <= ctrl_oe_d;
            mem_req_q   <= (state_d == S_FETCH);
            lw_valid_q  <= (state_q == S_C3_NOALLOC);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // data capture; wide registers carry no reset

    always_ff @(posedge sys_clk_in) begin
        if (wb_req && state_q == S_IDLE) begin
            addr_q      <= bus.system_address_bus;
            mask_q      <= bus.proc_write_mask;
            cacheable_q <= addr_cache;
        end
        if (state_q == S_C2) begin
            oct0_q      <= bus.system_data_bus;
            old_valid_q <= cache_tag_in.valid;
        end
        if (state_q == S_C3_ALLOC || state_q == S_C3_NOALLOC) begin
            oct1_q      <= bus.system_data_bus;
        end
        if (state_d == S_C5) begin
            fill_line_q <= fill_src;
        end
        if (state_q == S_C3_NOALLOC) begin
            lw_data_q   <= {bus.system_data_bus, oct0_q};
        end
        ctrl_data_q <= ctrl_data_d;
    end

    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            tag_out_q <= TAG_RESET;
        end else if (state_d == S_C4) begin
            tag_out_q.valid <= 1'b1;
            tag_out_q.dirty <= 1'b1;
            tag_out_q.tag   <= addr_q[ADDR_W-1:TAG_LSB];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs

    assign bus.proc_cycle_acknowledge         = ack_q;
    assign bus.proc_data_output_enable_n      = data_oe_n_q;
    assign bus.proc_data_word_select          = word_sel_q;
    assign bus.proc_dcache_invalidate_request = inval_q;
    assign bus.ctrl_data_out                  = ctrl_data_q;
    assign bus.ctrl_data_oe                   = ctrl_oe_q;

    assign early_output_enable_gate_out = early_gate_q;
    assign cache_tag_output_enable_out  = tag_oe_q;
    assign tag_output_gate_out          = tag_gate_q;
    assign system_data_enable_out       = sys_den_q;
    assign cache_tag_drive_out          = tag_drive_q;
    assign cache_tag_out                = tag_out_q;
    assign tag_write_enable_gate_out    = tag_we_q;
    assign data_write_enable_gate_out   = data_we_q;
    // sram strobes follow their gates one for one
    assign cache_tag_write_strobe_out   = tag_we_q;
    assign cache_data_write_strobe_out  = data_we_q;
    assign cache_data_addr_bit4_out     = bit4_q;
    assign mem_read_req_out             = mem_req_q;
    assign mem_read_addr_out            = {addr_q[ADDR_W-1:LINE_LSB],
                                           {LINE_LSB{1'b0}}};
    assign line_write_valid_out         = lw_valid_q;
    assign line_write_addr_out          = {addr_q[ADDR_W-1:LINE_LSB],
                                           {LINE_LSB{1'b0}}};
    assign line_write_data_out          = lw_data_q;
    assign line_write_mask_out          = mask_q;

endmodule : wbc_ctrl_end
`default_nettype wire

// ===== hw/wbc_proc_end.sv
// processor end: issues write block transactions on the system bus
`timescale 1ns/1ps
`default_nettype none
module wbc_proc_end
    import wbc_pkg::*;
(
    input  wire logic                  sys_clk_in,
    input  wire logic                  resetn_in,
    wbc_bus_if.proc                    bus,
    input  wire logic                  wb_start_in,
    input  wire logic [ADDR_W-1:0]     wb_addr_in,
    input  wire logic [LINE_W-1:0]     wb_line_in,
    input  wire logic [LINE_BYTES-1:0] wb_mask_in,
    output logic                       wb_busy_out,
    output logic                       wb_done_out,
    output logic                       dcache_invalidate_out
);

    typedef enum logic [1:0] {
        P_IDLE,
        P_SETUP,
        P_REQ
    } wbc_proc_state_t;

    wbc_proc_state_t          state_q;
    logic [SETUP_CNT_W-1:0]   setup_cnt_q;
    logic [ADDR_W-1:0]        addr_q;
    logic [LINE_BYTES-1:0]    mask_q;
    logic [OCT_W-1:0]         oct1_q;
    logic [OCT_W-1:0]         data_q;
    logic                     data_oe_q;
    logic                     sel_seen_q;
    wbc_code_t                req_q;
    logic                     busy_q;
    logic                     done_q;
    logic                     inval_q;

    // the long probe set-up covers the short one, so one wait serves
    // both the allocating and the non-allocating cases
    localparam logic [SETUP_CNT_W-1:0] SETUP_LAST =
        SETUP_CNT_W'(PROBE_SETUP_CYC - 1);

    wire start    = (state_q == P_IDLE) && wb_start_in;
    wire setup_ok = (state_q == P_SETUP) && (setup_cnt_q == SETUP_LAST);
    wire acked    = (state_q == P_REQ) &&
                    (bus.proc_cycle_acknowledge == ACK_OK);

    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            state_q     <= P_IDLE;
            setup_cnt_q <= '0;
            req_q       <= REQ_IDLE;
            data_oe_q   <= 1'b0;
            sel_seen_q  <= 1'b0;
            busy_q      <= 1'b0;
            done_q      <= 1'b0;
            inval_q     <= 1'b0;
        end else begin
            done_q  <= acked;
            inval_q <= bus.proc_dcache_invalidate_request;
            unique case (state_q)
                P_IDLE: begin
                    if (start) begin
                        state_q     <= P_SETUP;
                        setup_cnt_q <= '0;
                        busy_q      <= 1'b1;
                    end
                end
                P_SETUP: begin
                    setup_cnt_q <= setup_cnt_q + 1'b1;
                    if (setup_ok) begin
                        state_q    <= P_REQ;
                        req_q      <= REQ_WRITE_BLOCK;
                        data_oe_q  <= 1'b1;
                        sel_seen_q <= 1'b0;
                    end
                end
                P_REQ: begin
                    if (bus.proc_data_word_select) begin
                        sel_seen_q <= 1'b1;
                    end else if (sel_seen_q) begin
                        data_oe_q  <= 1'b0;
                    end
                    if (acked) begin
                        state_q   <= P_IDLE;
                        req_q     <= REQ_IDLE;
                        data_oe_q <= 1'b0;
                        busy_q    <= 1'b0;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (start) begin
            addr_q <= wb_addr_in;
            mask_q <= wb_mask_in;
            data_q <= wb_line_in[OCT_W-1:0];
            oct1_q <= wb_line_in[LINE_W-1:OCT_W];
        end else if (state_q == P_REQ && bus.proc_data_word_select) begin
            data_q <= oct1_q;
        end
    end

    assign bus.proc_cycle_request = req_q;
    assign bus.system_address_bus = addr_q;
    assign bus.proc_write_mask    = mask_q;
    assign bus.proc_data_bus      = data_q;
    assign bus.proc_data_oe       = data_oe_q;
    assign wb_busy_out            = busy_q;
    assign wb_done_out            = done_q;
    assign dcache_invalidate_out  = inval_q;

endmodule : wbc_proc_end
`default_nettype wire

// ===== test/wbc_bus_assertions.sv
// concurrent checks on the write block system bus
`timescale 1ns/1ps
`default_nettype none
module wbc_bus_assertions
    import wbc_pkg::*;
(
    input wire logic      sys_clk_in,
    input wire logic      resetn_in,
    input wire wbc_code_t proc_cycle_request,
    input wire wbc_code_t proc_cycle_acknowledge,
    input wire logic      proc_data_output_enable_n,
    input wire logic      proc_data_word_select,
    input wire logic      proc_dcache_invalidate_request,
    input wire logic      proc_data_oe,
    input wire logic [ADDR_W-1:0] system_address_bus,
    input wire logic      ctrl_data_oe
);
    logic ws, ok, idle, oen, cde;
    assign ws   = proc_data_word_select;
    assign ok   = proc_cycle_acknowledge == ACK_OK;
    assign idle = proc_cycle_acknowledge == ACK_IDLE;
    assign oen  = proc_data_output_enable_n;
    assign cde  = ctrl_data_oe;
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!resetn_in);
    ////////////////////////////////////////////////////////////////////
    a_req_opens_data: assert property (
        $rose(proc_cycle_request == REQ_WRITE_BLOCK) |=> ws && !oen)
        else $error("request did not open the data bus");
    a_second_octaword: assert property (
        ws |=> !oen && proc_data_oe && !ws)
        else $error("second octaword cycle wrong");
    a_proc_releases: assert property (ws |-> ##2 !proc_data_oe)
        else $error("processor still drives in cycle 4");
    a_no_drive_clash: assert property (
        !(cde && proc_data_oe && !oen))
        else $error("both ends drive the data bus");
    a_ack_bounded: assert property (ws |-> ##[1:20] ok)
        else $error("no acknowledge after data select");
    a_ack_gap: assert property (ws |=> ##1 idle [*3])
        else $error("acknowledge in cycles 4 to 6");
    a_ack_one_cycle: assert property (ok |=> idle)
        else $error("acknowledge longer than one cycle");
    a_fill_then_ack: assert property (
        $rose(cde) |-> cde [*2] ##1 (!cde && ok && !oen))
        else $error("fill not two cycles then acknowledge");
    a_addr_setup: assert property (
        $rose(proc_cycle_request == REQ_WRITE_BLOCK) |->
        $stable(system_address_bus))
        else $error("address changed as the request rose");
    a_inv_in_fill: assert property (
        proc_dcache_invalidate_request |-> $rose(cde))
        else $error("invalidate outside first fill cycle");
endmodule : wbc_bus_assertions
`default_nettype wire

// ===== test/cpu_write_block_cache_seq_tb.sv
// self-checking bench joining both ends of the write block bus
`timescale 1ns/1ps
`default_nettype none
module cpu_write_block_cache_seq_tb;
    import wbc_pkg::*;
    typedef struct packed {
        logic al; logic [ADDR_W-1:0] a; logic [LINE_BYTES-1:0] m;
        wbc_tag_t t; logic fill; logic inv;
    } wbc_row_t;
    logic sys_clk_in = 1'b0, resetn_in = 1'b0, wb_start_in = 1'b0;
    logic write_allocate_enable_in = 1'b0, mem_read_valid_in = 1'b0;
    logic [ADDR_W-1:0]     wb_addr_in = '0;
    logic [LINE_W-1:0]     wb_line_in = '0;
    logic [LINE_BYTES-1:0] wb_mask_in = '0;
    wbc_tag_t              cache_tag_in = TAG_RESET;
    logic [LINE_W-1:0]     mem_read_data_in = {8{32'hdead_beef}};
    logic mem_read_req_out, wb_done_out, cache_data_write_strobe_out;
    logic cache_tag_write_strobe_out, line_write_valid_out, inv;
    logic early_output_enable_gate_out, cache_data_addr_bit4_out;
    logic [ADDR_W-1:0]     line_write_addr_out;
    logic [LINE_BYTES-1:0] line_write_mask_out;
    wbc_tag_t              cache_tag_out, tg;
    logic [LINE_W-1:0]     line_write_data_out;
    logic [OCT_W-1:0]      fl [2];
    int err_total = 0, checked = 0, cyc = 0, t_ws, t_ack, nf, ndw, ntw;
    int nb4, neg;
    wbc_row_t rows [6];
    wbc_bus_if bus ();
    ////////////////////////////////////////////////////////////////////
    wbc_ctrl_end i_wbc_ctrl_end (.sys_clk_in, .resetn_in, .bus,
        .write_allocate_enable_in, .cache_tag_in,
        .early_output_enable_gate_out, .cache_tag_output_enable_out(),
        .tag_output_gate_out(), .system_data_enable_out(),
        .cache_tag_drive_out(), .cache_tag_out,
        .tag_write_enable_gate_out(), .data_write_enable_gate_out(),
        .cache_tag_write_strobe_out, .cache_data_write_strobe_out,
        .cache_data_addr_bit4_out, .mem_read_req_out,
        .mem_read_addr_out(), .mem_read_valid_in, .mem_read_data_in,
        .line_write_valid_out, .line_write_addr_out,
        .line_write_data_out, .line_write_mask_out);
    wbc_proc_end i_wbc_proc_end (.sys_clk_in, .resetn_in, .bus,
        .wb_start_in, .wb_addr_in, .wb_line_in, .wb_mask_in,
        .wb_busy_out(), .wb_done_out, .dcache_invalidate_out());
    wbc_bus_assertions i_wbc_bus_assertions (.sys_clk_in, .resetn_in,
        .proc_cycle_request(bus.proc_cycle_request),
        .proc_cycle_acknowledge(bus.proc_cycle_acknowledge),
        .proc_data_output_enable_n(bus.proc_data_output_enable_n),
        .proc_data_word_select(bus.proc_data_word_select),
        .proc_dcache_invalidate_request(bus.proc_dcache_invalidate_request),
        .proc_data_oe(bus.proc_data_oe), .ctrl_data_oe(bus.ctrl_data_oe),
        .system_address_bus(bus.system_address_bus));
    ////////////////////////////////////////////////////////////////////
    always #5 sys_clk_in = ~sys_clk_in;
    // memory answers half a cycle late so the fill really has to wait
    always @(negedge sys_clk_in)
        mem_read_valid_in <= mem_read_req_out & ~mem_read_valid_in;
    // sample mid-cycle, clear of the edge that launches the outputs
    always @(negedge sys_clk_in) begin
        cyc++;
        nb4 += cache_data_addr_bit4_out;
        neg += !early_output_enable_gate_out;
        if (cache_tag_write_strobe_out) tg = cache_tag_out;
        if (bus.proc_data_word_select) t_ws = cyc;
        if (bus.proc_cycle_acknowledge == ACK_OK) t_ack = cyc;
        if (bus.ctrl_data_oe && nf < 2) fl[nf++] = bus.system_data_bus;
        ndw += cache_data_write_strobe_out;
        ntw += cache_tag_write_strobe_out;
        inv |= bus.proc_dcache_invalidate_request;
    end
    task automatic chk(input logic [LINE_W-1:0] g, e);
        checked++;
        if (g !== e) begin
            err_total++;
            $display("wrong value at %0t: got %h want %h", $time, g, e);
        end
    endtask : chk
    function automatic logic [LINE_W-1:0] mrg(input wbc_row_t r,
        input logic [LINE_W-1:0] ln);
        for (int b = 0; b < LINE_BYTES; b++)
            mrg[b*8+:8] = r.m[b] ? ln[b*8+:8] : mem_read_data_in[b*8+:8];
    endfunction : mrg
    task automatic run(input wbc_row_t r, input logic [LINE_W-1:0] ln);
        int k = 0;
        @(negedge sys_clk_in);
        {write_allocate_enable_in, wb_addr_in, wb_mask_in} = {r.al, r.a, r.m};
        cache_tag_in = r.t;
        wb_line_in = ln;
        wb_start_in = 1'b1;
        {nf, ndw, ntw, nb4, neg, t_ws, t_ack, inv, tg} = '0;
        @(negedge sys_clk_in);
        wb_start_in = 1'b0;
        while (wb_done_out !== 1'b1 && k++ < 40) @(negedge sys_clk_in);
        chk(wb_done_out, 1'b1);
        if (!r.fill || r.m == '1) chk(t_ack - t_ws, r.fill ? 5 : 1);
        chk(nf, r.fill ? 2 : 0);
        if (r.fill) chk({fl[1], fl[0]}, mrg(r, ln));
        chk({ndw, ntw, nb4}, r.fill ? {32'd2, 32'd1, 32'd2} : 96'h0);
        if (r.fill) chk(tg, {2'b11, r.a[ADDR_W-1:TAG_LSB]});
        chk(neg, r.fill ? 5 + (r.m != '1) : 1);
        chk({line_write_valid_out, line_write_addr_out,
            line_write_mask_out}, {!r.fill, r.a, r.m});
        chk(inv, r.inv);
        if (!r.fill) chk(line_write_data_out, ln);
    endtask : run
    task automatic report_and_stop;
        $display("errors %0d of %0d checks", err_total, checked);
        if (err_total == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : report_and_stop
    ////////////////////////////////////////////////////////////////////
    initial begin
        rows[0] = '{1'b1, 34'h0_0000_0100, '1, TAG_RESET, 1'b1, 1'b0};
        rows[1] = '{1'b1, 34'h0_0002_0120, '1, '{1'b1, 1'b0, 17'h3}, 1'b1, 1'b1};
        rows[2] = '{1'b0, 34'h0_0000_0140, '1, TAG_RESET, 1'b0, 1'b0};
        rows[3] = '{1'b1, 34'h2_0000_0160, '1, TAG_RESET, 1'b0, 1'b0};
        rows[4] = '{1'b1, 34'h0_0004_0180, '1, '{1'b1, 1'b1, 17'h1}, 1'b0, 1'b0};
        rows[5] = '{1'b1, 34'h0_0000_01a0, 32'h00ff_f00f, TAG_RESET, 1'b1, 1'b0};
        repeat (20) @(negedge sys_clk_in);
        chk({bus.proc_data_output_enable_n, bus.proc_cycle_acknowledge}, 4'h8);
        resetn_in = 1'b1;
        for (int i = 0; i < 6; i++) run(rows[i], {8{32'h1357_9bd0 + i}});
        // reset in mid-fill must leave the bus idle and usable again
        wb_start_in = 1'b1;
        repeat (7) @(negedge sys_clk_in);
        wb_start_in = 1'b0;
        resetn_in = 1'b0;
        #1 chk({bus.proc_data_output_enable_n, bus.proc_cycle_acknowledge,
            bus.ctrl_data_oe}, 5'h10);
        @(negedge sys_clk_in);
        resetn_in = 1'b1;
        run(rows[2], {8{32'h2468_ace0}});
        report_and_stop();
    end
    initial begin
        #20us;
        err_total++;
        report_and_stop();
    end
endmodule : cpu_write_block_cache_seq_tb
`default_nettype wire
